// ### core/phase_counter.sv
`timescale 1ns/1ps
module phase_counter
  import pll_seq_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] count_i,
  // Status
  output logic                  busy_o,
  output logic                  expire_o
);

  logic [CNT_W-1:0] cnt;

  // Last counted cycle; a zero count acts as one
  assign expire_o = busy_o && (cnt <= CNT_W'(1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt    <= count_i;
      busy_o <= 1'b1;
    end else if (expire_o) begin
      busy_o <= 1'b0;
    end else if (busy_o) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

endmodule

// ### core/phy_pll_reset_sequencer.sv
// Summary of operation
// - All sequencing durations are counted in configuration clock cycles.
// - PLL power-down pin held for power-down count, then released.
// - PLL reset pin then held for reset count, at least nine microseconds.
// - Gear-shift pin released gear-shift count after PLL reset release.
// - PLL ready only after lock-wait count following PLL reset release.
// - After calibration done, PHY reset held for extension count, then released.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module phy_pll_reset_sequencer
  import pll_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // PHY calibration
  input  wire logic        phy_cal_done_i,
  // PLL and PHY pins
  output logic             pll_powerdown_o,
  output logic             pll_reset_o,
  output logic             pll_gearshift_o,
  output logic             phy_reset_o,
  output logic             pll_ready_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] pll_powerdown_gearshift_phy_reset_timing;
  logic [31:0] pll_lock_and_reset_timing;
  logic        start_req;
  seq_state_e  state;
  seq_state_e  next_state;
  logic        cal_sync1;
  logic        cal_sync2;

  logic [10:0] pll_powerdown_hold_count;
  logic [14:0] pll_gearshift_release_count;
  logic [5:0]  phy_reset_extension_count;
  logic [15:0] pll_lock_wait_count;
  logic [12:0] pll_reset_hold_count;

  assign pll_powerdown_hold_count    = pll_powerdown_gearshift_phy_reset_timing[PD_MSB:PD_LSB];
  assign pll_gearshift_release_count = pll_powerdown_gearshift_phy_reset_timing[GS_MSB:GS_LSB];
  assign phy_reset_extension_count   =
    pll_powerdown_gearshift_phy_reset_timing[PHY_MSB:PHY_LSB];
  assign pll_lock_wait_count         = pll_lock_and_reset_timing[LOCK_MSB:LOCK_LSB];
  assign pll_reset_hold_count        = pll_lock_and_reset_timing[RST_MSB:RST_LSB];

  // ****************************************
  // Bus slave
  // ****************************************
  logic        bus_req;
  logic        wr_commit;
  logic [31:0] be_mask;
  logic [31:0] status_word;

  assign bus_req   = avs_read_i || avs_write_i;
  assign wr_commit = avs_write_i && !avs_waitrequest_o;
  assign be_mask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    status_word                  = '0;
    status_word[STAT_BUSY_BIT]   = (state != ST_IDLE) && (state != ST_DONE);
    status_word[STAT_READY_BIT]  = pll_ready_o;
    status_word[STAT_DONE_BIT]   = (state == ST_DONE);
    status_word[STAT_PD_BIT]     = pll_powerdown_o;
    status_word[STAT_RST_BIT]    = pll_reset_o;
    status_word[STAT_GS_BIT]     = pll_gearshift_o;
    status_word[STAT_PHYRST_BIT] = phy_reset_o;
  end

  // One wait cycle, then answer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      unique case (avs_address_i)
        ADDR_TIMING0:   avs_readdata_o <= pll_powerdown_gearshift_phy_reset_timing;
        ADDR_TIMING1:   avs_readdata_o <= pll_lock_and_reset_timing;
        ADDR_CTRL_STAT: avs_readdata_o <= status_word;
        default:        avs_readdata_o <= '0;
      endcase
    end
  end

  // Timing registers; new values used at the next phase load
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pll_powerdown_gearshift_phy_reset_timing <= TIMING0_RESET;
      pll_lock_and_reset_timing                <= TIMING1_RESET;
    end else if (wr_commit) begin
      if (avs_address_i == ADDR_TIMING0) begin
        pll_powerdown_gearshift_phy_reset_timing <=
          (pll_powerdown_gearshift_phy_reset_timing & ~be_mask) |
          (avs_writedata_i & be_mask);
      end
      if (avs_address_i == ADDR_TIMING1) begin
        pll_lock_and_reset_timing <=
          (pll_lock_and_reset_timing & ~(be_mask & TIMING1_RW_MASK)) |
          (avs_writedata_i & be_mask & TIMING1_RW_MASK);
      end
    end
  end

  // Start request; a pending start is never lost
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_req <= 1'b0;
    end else if (wr_commit && (avs_address_i == ADDR_CTRL_STAT) &&
                 avs_byteenable_i[0] && avs_writedata_i[CTRL_START_BIT]) begin
      start_req <= 1'b1;
    end else if ((state == ST_IDLE) || (state == ST_DONE)) begin
      start_req <= 1'b0;
    end
  end

  // ****************************************
  // Calibration done synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cal_sync1 <= 1'b0;
      cal_sync2 <= 1'b0;
    end else begin
      cal_sync1 <= phy_cal_done_i;
      cal_sync2 <= cal_sync1;
    end
  end

  // ****************************************
  // Phase counters
  // ****************************************
  logic             main_start;
  logic [CNT_W-1:0] main_count;
  logic             main_expire;
  logic             main_busy;
  logic             side_start;
  logic             side_busy;
  logic             side_expire;

  phase_counter u_main_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (main_start),
    .count_i   (main_count),
    .busy_o    (main_busy),
    .expire_o  (main_expire)
  );

  // Gear-shift interval runs beside the lock wait
  phase_counter u_gs_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (side_start),
    .count_i   (CNT_W'(pll_gearshift_release_count)),
    .busy_o    (side_busy),
    .expire_o  (side_expire)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    main_start = 1'b0;
    main_count = '0;
    side_start = 1'b0;
    unique case (state)
      ST_IDLE, ST_DONE: begin
        if (start_req) begin
          next_state = ST_PD_HOLD;
          main_start = 1'b1;
          main_count = CNT_W'(pll_powerdown_hold_count);
        end
      end
      ST_PD_HOLD: begin
        if (main_expire) begin
          next_state = ST_RST_HOLD;
          main_start = 1'b1;
          main_count = CNT_W'(pll_reset_hold_count);
        end
      end
      ST_RST_HOLD: begin
        if (main_expire) begin
          next_state = ST_LOCK_WAIT;
          main_start = 1'b1;
          main_count = pll_lock_wait_count;
          side_start = 1'b1;
        end
      end
      ST_LOCK_WAIT: begin
        // Either interval may end first; wait for both
        if ((main_expire || !main_busy) && (side_expire || !side_busy)) begin
          next_state = ST_CAL_WAIT;
        end
      end
      ST_CAL_WAIT: begin
        if (cal_sync2) begin
          next_state = ST_PHY_EXT;
          main_start = 1'b1;
          main_count = CNT_W'(phy_reset_extension_count);
        end
      end
      ST_PHY_EXT: begin
        if (main_expire) begin
          next_state = ST_DONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pll_powerdown_o <= 1'b1;
      pll_reset_o     <= 1'b1;
      pll_gearshift_o <= 1'b1;
      phy_reset_o     <= 1'b1;
      pll_ready_o     <= 1'b0;
    end else begin
      pll_powerdown_o <= (next_state == ST_IDLE) || (next_state == ST_PD_HOLD) ||
                         (pll_powerdown_o && next_state == ST_DONE && state == ST_DONE);
      pll_reset_o     <= (next_state inside {ST_IDLE, ST_PD_HOLD, ST_RST_HOLD});
      if (side_start || main_start && next_state == ST_PD_HOLD) begin
        pll_gearshift_o <= 1'b1;
      end else if (side_expire) begin
        pll_gearshift_o <= 1'b0;
      end
      pll_ready_o     <= (next_state inside {ST_CAL_WAIT, ST_PHY_EXT, ST_DONE});
      phy_reset_o     <= (next_state != ST_DONE);
    end
  end

endmodule

// ### dv/phy_pll_reset_sequencer_tb.sv
`timescale 1ns/1ps
module phy_pll_reset_sequencer_tb;
  import pll_seq_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic avs_waitrequest_o, phy_cal_done_i, pll_powerdown_o, pll_reset_o;
  logic pll_gearshift_o, phy_reset_o, pll_ready_o;
  int n_errors = 0, samples_checked = 0, cyc = 0, t0, n, mx;
  int t_pd, t_rst, t_gs, t_rdy, t_cal, t_phy;
  int pd_c[2] = '{3, 1}, rs_c[2] = '{6, 2}, gs_c[2] = '{5, 12};
  int lk_c[2] = '{9, 4}, ph_c[2] = '{4, 15};
  phy_pll_reset_sequencer uut (.*);
  pll_phy_model u_far (.clk_sys_i(clk_sys_i), .pll_ready_i(pll_ready_o),
    .cal_done_o(phy_cal_done_i));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Falling edge count, race free at rising edge
  always @(negedge clk_sys_i) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      summarize();
    end
  end
  always @(negedge pll_powerdown_o) t_pd = cyc;
  always @(negedge pll_reset_o) t_rst = cyc;
  always @(negedge pll_gearshift_o) t_gs = cyc;
  always @(posedge pll_ready_o) t_rdy = cyc;
  always @(posedge phy_cal_done_i) t_cal = cyc;
  always @(negedge phy_reset_o) t_phy = cyc;
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int d, input int lo, input int hi);
    samples_checked++;
    if (d < lo || d > hi) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, d, lo);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk({pll_powerdown_o, pll_reset_o, pll_gearshift_o,
         phy_reset_o, pll_ready_o}, 5'h1e);
    bus(0, ADDR_TIMING0, 0); chk(q, TIMING0_RESET);
    bus(0, ADDR_TIMING1, 0); chk(q, TIMING1_RESET);
    bus(0, 4'hc, 0); chk(q, 32'h0);
    bus(1, ADDR_TIMING1, 32'hffffffff);
    bus(0, ADDR_TIMING1, 0); chk(q, TIMING1_RW_MASK);
    for (int i = 0; i < 2; i++) begin
      // Short counts keep the run brief; second set uses the recommended extension
      bus(1, ADDR_TIMING0, {pd_c[i][10:0], gs_c[i][14:0], ph_c[i][5:0]});
      bus(1, ADDR_TIMING1, {lk_c[i][15:0], 3'h0, rs_c[i][12:0]});
      bus(1, ADDR_CTRL_STAT, 32'h1);
      t0 = cyc;
      n = 0;
      while ((t_phy <= t0 || phy_reset_o !== 1'b0) && n < 500) begin
        @(posedge clk_sys_i);
        n++;
      end
      if (n >= 500) n_errors++;
      mx = (lk_c[i] > gs_c[i]) ? lk_c[i] : gs_c[i];
      chk_rng(t_pd - t0, pd_c[i], pd_c[i]);
      chk_rng(t_rst - t_pd, rs_c[i], rs_c[i]);
      chk_rng(t_gs - t_rst, gs_c[i], gs_c[i]);
      chk_rng(t_rdy - t_rst, mx, mx);
      // Two-flop sync plus one load cycle after done
      chk_rng(t_phy - t_cal, ph_c[i] + 3, ph_c[i] + 3);
      bus(0, ADDR_CTRL_STAT, 0); chk(q, 32'h6);
    end
    summarize();
  end
endmodule

// ### dv/pll_phy_model.sv
`timescale 1ns/1ps
module pll_phy_model #(
  parameter int CAL_DLY = 4
) (
  // Clock
  input  wire logic clk_sys_i,
  // Pins from the sequencer
  input  wire logic pll_ready_i,
  // Calibration result
  output logic      cal_done_o = 1'b0
);
  int cnt = 0;
  // Calibration runs only on a locked PLL, done held as a level
  always @(posedge clk_sys_i) begin
    if (!pll_ready_i) begin
      cnt <= 0;
      cal_done_o <= 1'b0;
    end else if (cnt < CAL_DLY) begin
      cnt <= cnt + 1;
    end else begin
      cal_done_o <= 1'b1;
    end
  end
endmodule

// ### dv/seq_pins_sva.sv
`timescale 1ns/1ps
module seq_pins_sva (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Observed pins
  input wire logic phy_cal_done_i,
  input wire logic pll_powerdown_o,
  input wire logic pll_reset_o,
  input wire logic pll_gearshift_o,
  input wire logic phy_reset_o,
  input wire logic pll_ready_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Phase order
  // ****************************************
  sequence s_pd_fall; $fell(pll_powerdown_o); endsequence
  sequence s_rst_fall; $fell(pll_reset_o); endsequence
  property p_pd_then_rst; s_pd_fall |-> pll_reset_o && pll_gearshift_o; endproperty
  property p_rst_order; s_rst_fall |-> !pll_powerdown_o && $past(!pll_powerdown_o); endproperty
  property p_gs_order; pll_reset_o |-> pll_gearshift_o; endproperty
  property p_gs_late; s_rst_fall |-> pll_gearshift_o; endproperty
  property p_ready_clean;
    pll_ready_o |-> !pll_powerdown_o && !pll_reset_o && !pll_gearshift_o;
  endproperty
  property p_ready_late; $rose(pll_ready_o) |-> $past(!pll_reset_o); endproperty
  property p_phy_cal; $fell(phy_reset_o) |-> $past(phy_cal_done_i, 2) && pll_ready_o; endproperty
  property p_phy_rel; !phy_reset_o |-> pll_ready_o; endproperty
  a_pd_then_rst: assert property (p_pd_then_rst) else $error("reset not held");
  a_rst_order: assert property (p_rst_order) else $error("reset left too early");
  a_gs_order: assert property (p_gs_order) else $error("gearshift low during reset");
  a_gs_late: assert property (p_gs_late) else $error("gearshift not delayed");
  a_ready_clean: assert property (p_ready_clean) else $error("ready with pin active");
  a_ready_late: assert property (p_ready_late) else $error("ready without lock wait");
  a_phy_cal: assert property (p_phy_cal) else $error("phy reset left early");
  a_phy_rel: assert property (p_phy_rel) else $error("phy reset low before ready");
endmodule
bind phy_pll_reset_sequencer seq_pins_sva u_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .phy_cal_done_i(phy_cal_done_i),
  .pll_powerdown_o(pll_powerdown_o), .pll_reset_o(pll_reset_o),
  .pll_gearshift_o(pll_gearshift_o), .phy_reset_o(phy_reset_o), .pll_ready_o(pll_ready_o)
);

// ### pkg/pll_seq_pkg.sv
package pll_seq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  ADDR_TIMING0   = 4'h0;
  localparam logic [3:0]  ADDR_TIMING1   = 4'h4;
  localparam logic [3:0]  ADDR_CTRL_STAT = 4'h8;

  // ****************************************
  // Field layout, timing register 0
  // ****************************************
  localparam int PD_MSB  = 31;
  localparam int PD_LSB  = 21;
  localparam int GS_MSB  = 20;
  localparam int GS_LSB  = 6;
  localparam int PHY_MSB = 5;
  localparam int PHY_LSB = 0;

  // ****************************************
  // Field layout, timing register 1
  // ****************************************
  localparam int LOCK_MSB = 31;
  localparam int LOCK_LSB = 16;
  localparam int RST_MSB  = 12;
  localparam int RST_LSB  = 0;
  localparam logic [31:0] TIMING1_RW_MASK = 32'hffff_1fff;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [10:0] PD_RESET   = 11'h216;
  localparam logic [14:0] GS_RESET   = 15'h856;
  localparam logic [5:0]  PHY_RESET  = 6'h0f;
  localparam logic [15:0] LOCK_RESET = 16'hd056;
  localparam logic [12:0] RST_RESET  = 13'h12c0;
  localparam logic [31:0] TIMING0_RESET = {PD_RESET, GS_RESET, PHY_RESET};
  localparam logic [31:0] TIMING1_RESET = {LOCK_RESET, 3'h0, RST_RESET};

  // ****************************************
  // Control and status bits
  // ****************************************
  localparam int CTRL_START_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_READY_BIT  = 1;
  localparam int STAT_DONE_BIT   = 2;
  localparam int STAT_PD_BIT     = 4;
  localparam int STAT_RST_BIT    = 5;
  localparam int STAT_GS_BIT     = 6;
  localparam int STAT_PHYRST_BIT = 7;

  // ****************************************
  // Counters and sequencer
  // ****************************************
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PD_HOLD,
    ST_RST_HOLD,
    ST_LOCK_WAIT,
    ST_CAL_WAIT,
    ST_PHY_EXT,
    ST_DONE
  } seq_state_e;

endpackage
